//--- inc/debug_wire_pkg.sv
package debug_wire_pkg;

    // ------------------------------------------------------------
    // Counts of target clock cycles
    // ------------------------------------------------------------
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] ACK_LOW_CYCLES = 6'h10;
    localparam logic [CNT_W-1:0] STEAL_AFTER_CYCLES = 6'h08;
    localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [2:0] SYNC_RESET = 3'h7;
    localparam logic [1:0] RST_SYNC_RESET = 2'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_BUS = 3'b001,
        ST_WAIT_PIN = 3'b010,
        ST_ACK_LOW = 3'b011,
        ST_BLOCKED = 3'b100
    } ack_state_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic is_read;
        logic is_write;
        logic needs_cpu;
    } cmd_t;

    typedef struct packed {
        logic req;
        logic steal;
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } bus_req_t;

    typedef struct packed {
        ack_state_t state;
        logic [CNT_W-1:0] count;
        cmd_t cmd;
        logic [15:0] word;
        logic rdata_valid;
    } ack_regs_t;

endpackage

//--- src/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic pin_in,
    output logic late_a,
    output logic late_b
);

    logic [2:0] stage;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage <= debug_wire_pkg::SYNC_RESET;
        end
        else
        begin
            stage <= {stage[1:0], pin_in};
        end
    end

    assign late_a = stage[1];
    assign late_b = stage[2];

endmodule

//--- src/debug_wire_ack_handshake.sv
`timescale 1ns/1ps
module debug_wire_ack_handshake
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input debug_wire_pkg::cmd_t cmd,
    output logic cmd_ready,
    input wire logic host_abort,
    input wire logic cpu_wait_stop,
    output debug_wire_pkg::bus_req_t bus,
    input wire logic bus_grant,
    input wire logic [15:0] bus_rdata,
    output logic [15:0] rdata_word,
    output logic rdata_valid,
    output logic ack_busy,
    input wire logic debug_wire_pin_in,
    output logic debug_wire_pin_out,
    output logic debug_wire_pin_oe
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync;
    logic rst_n_int;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_sync <= debug_wire_pkg::RST_SYNC_RESET;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n_int = rst_sync[1];

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    logic pin_a;
    logic pin_b;
    logic pin_idle_high;

    pin_sync u_pin_sync
    (
        .clock(clock),
        .rst_n(rst_n_int),
        .pin_in(debug_wire_pin_in),
        .late_a(pin_a),
        .late_b(pin_b)
    );

    // Pin counts as high only once both late stages agree
    assign pin_idle_high = pin_a & pin_b;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic cmd_take;
    debug_wire_pkg::ack_state_t take_state;

    assign cmd_take = cmd_valid & cmd_ready;

    // Wait or stop only counts at the edge that takes the command
    always_comb
    begin
        if (cmd.needs_cpu && cpu_wait_stop)
        begin
            take_state = debug_wire_pkg::ST_BLOCKED;
        end
        else if (cmd.is_read || cmd.is_write)
        begin
            take_state = debug_wire_pkg::ST_BUS;
        end
        else
        begin
            take_state = debug_wire_pkg::ST_WAIT_PIN;
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    debug_wire_pkg::ack_regs_t cur;
    debug_wire_pkg::ack_regs_t next_cur;

    always_comb
    begin
        next_cur = cur;
        next_cur.rdata_valid = 1'b0;
        case (cur.state)
            debug_wire_pkg::ST_IDLE:
            begin
                next_cur.count = debug_wire_pkg::CNT_RESET;
                // Opcode and address arrive already decoded
                if (cmd_take)
                begin
                    next_cur.cmd = cmd;
                    next_cur.state = take_state;
                end
            end
            debug_wire_pkg::ST_BUS:
            begin
                // Wait count saturates where stealing starts
                if (cur.count != debug_wire_pkg::STEAL_AFTER_CYCLES)
                begin
                    next_cur.count = cur.count + 6'h01;
                end
                if (bus_grant)
                begin
                    if (cur.cmd.is_read)
                    begin
                        next_cur.word = bus_rdata;
                    end
                    next_cur.state = debug_wire_pkg::ST_WAIT_PIN;
                end
            end
            debug_wire_pkg::ST_WAIT_PIN:
            begin
                // Never start the edge while the host still holds the line low
                next_cur.count = debug_wire_pkg::CNT_RESET;
                if (pin_idle_high)
                begin
                    next_cur.state = debug_wire_pkg::ST_ACK_LOW;
                    next_cur.rdata_valid = cur.cmd.is_read;
                end
            end
            debug_wire_pkg::ST_ACK_LOW:
            begin
                // Hold low for the full pulse length, then let go
                next_cur.count = cur.count + 6'h01;
                if (cur.count == debug_wire_pkg::ACK_LOW_CYCLES - 6'h01)
                begin
                    next_cur.state = debug_wire_pkg::ST_IDLE;
                end
            end
            debug_wire_pkg::ST_BLOCKED:
            begin
                // Stays here with no time limit
                next_cur.state = debug_wire_pkg::ST_BLOCKED;
            end
            default:
            begin
                next_cur.state = debug_wire_pkg::ST_IDLE;
            end
        endcase
        // Abort frees any pending command
        if (host_abort && cur.state != debug_wire_pkg::ST_IDLE)
        begin
            next_cur.state = debug_wire_pkg::ST_IDLE;
            next_cur.count = debug_wire_pkg::CNT_RESET;
            next_cur.rdata_valid = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n_int)
    begin
        if (!rst_n_int)
        begin
            cur.state <= debug_wire_pkg::ST_IDLE;
            cur.count <= debug_wire_pkg::CNT_RESET;
            cur.cmd <= '0;
            cur.word <= debug_wire_pkg::WORD_RESET;
            cur.rdata_valid <= 1'b0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // Handshake outputs
    // ------------------------------------------------------------
    // New commands only accepted when nothing is pending
    assign cmd_ready = (cur.state == debug_wire_pkg::ST_IDLE);
    assign ack_busy = (cur.state != debug_wire_pkg::ST_IDLE);

    // ------------------------------------------------------------
    // Bus request
    // ------------------------------------------------------------
    // Word address; the host picks its byte from the returned word
    always_comb
    begin
        bus.req = (cur.state == debug_wire_pkg::ST_BUS);
        bus.steal = bus.req && (cur.count == debug_wire_pkg::STEAL_AFTER_CYCLES);
        bus.we = cur.cmd.is_write;
        bus.addr = {cur.cmd.addr[15:1], 1'b0};
        bus.wdata = cur.cmd.wdata;
    end

    // ------------------------------------------------------------
    // Read data return
    // ------------------------------------------------------------
    assign rdata_word = cur.word;
    assign rdata_valid = cur.rdata_valid;

    // ------------------------------------------------------------
    // Debug pin drive
    // ------------------------------------------------------------
    // Only ever drives low; the high level comes from the pull-up
    assign debug_wire_pin_out = 1'b0;
    assign debug_wire_pin_oe = (cur.state == debug_wire_pkg::ST_ACK_LOW);

endmodule

//--- test/debug_wire_ack_handshake_assertions.sv
`timescale 1ns/1ps
module debug_wire_ack_handshake_assertions
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input debug_wire_pkg::cmd_t cmd,
    input wire logic cmd_ready,
    input wire logic host_abort,
    input wire logic cpu_wait_stop,
    input debug_wire_pkg::bus_req_t bus,
    input wire logic bus_grant,
    input wire logic rdata_valid,
    input wire logic ack_busy,
    input wire logic debug_wire_pin_out,
    input wire logic debug_wire_pin_oe
);
    wire oe = debug_wire_pin_oe;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ------------------------------
    // Handshake checks
    // ------------------------------
    property p_len;
        disable iff (!rst_n || host_abort)
        $rose(oe) |-> ##15 oe ##1 !oe;
    endproperty
    property p_pend; ack_busy && !oe && !bus.req && !host_abort |=> ack_busy; endproperty
    property p_low; oe |-> !debug_wire_pin_out; endproperty
    property p_rv; rdata_valid |-> $rose(oe); endproperty
    property p_drop; bus.req && bus_grant |=> !bus.req; endproperty
    property p_even; bus.req |-> !bus.addr[0]; endproperty
    property p_hold; bus.req && !bus_grant |=> $stable(bus.addr) && $stable(bus.we); endproperty
    property p_idle; cmd_ready |-> !oe; endproperty
    property p_abort; host_abort && ack_busy |=> cmd_ready && !oe; endproperty
    property p_stop;
        disable iff (!rst_n || host_abort)
        cmd_valid && cmd_ready && cmd.needs_cpu && cpu_wait_stop |=> !oe [*8];
    endproperty
    a_len: assert property (p_len) else $error("ack low length wrong");
    a_low: assert property (p_low) else $error("pin driven high");
    a_rv: assert property (p_rv) else $error("read data not with ack");
    a_drop: assert property (p_drop) else $error("bus request held");
    a_even: assert property (p_even) else $error("odd bus address");
    a_hold: assert property (p_hold) else $error("bus request moved");
    a_idle: assert property (p_idle) else $error("pin driven when idle");
    a_abort: assert property (p_abort) else $error("abort not taken");
    a_stop: assert property (p_stop) else $error("ack for dropped command");
    a_pend: assert property (p_pend) else $error("pending command lost");
    c_ack: cover property ($rose(oe));
    c_rv: cover property (rdata_valid);
    c_abort: cover property (host_abort && ack_busy);
    c_drop: cover property (cmd_valid && cmd_ready && cmd.needs_cpu && cpu_wait_stop);
    c_steal: cover property (bus.steal && bus_grant);
endmodule
bind debug_wire_ack_handshake debug_wire_ack_handshake_assertions chk_i (.*);

//--- test/debug_host_model.sv
`timescale 1ns/1ps
module debug_host_model
(
    input wire logic clock,
    input wire logic pin_oe,
    input wire logic pin_out,
    output logic pin,
    output int ack_len,
    output int ack_count
);
    int run = 0;
    // Only low is driven; any high comes from the pull-up
    assign pin = pin_oe ? pin_out : 1'b1;
    initial
    begin
        ack_len = 0;
        ack_count = 0;
    end
    // Measures each low pulse; the bench reads data only after one
    always @(posedge clock)
    begin
        if (!pin)
            run <= run + 1;
        else if (run != 0)
        begin
            ack_len <= run;
            ack_count <= ack_count + 1;
            run <= 0;
        end
    end
endmodule

//--- test/debug_wire_ack_handshake_tb.sv
`timescale 1ns/1ps
module debug_wire_ack_handshake_tb;
    logic clock = 0;
    logic rst_n = 0;
    logic cmd_valid = 0;
    debug_wire_pkg::cmd_t cmd = '0;
    logic host_abort = 0;
    logic cpu_wait_stop = 0;
    logic bus_grant = 0;
    logic [15:0] bus_rdata = 16'h0000;
    debug_wire_pkg::bus_req_t bus;
    logic [15:0] rdata_word;
    logic cmd_ready, rdata_valid, ack_busy, pin, pin_out, pin_oe;
    int ack_len, ack_count;
    int fails = 0;
    int cmp_count = 0;
    int rv_count = 0;
    always #2 clock = ~clock;
    // Counts read data strobes as the host would see them
    always @(posedge clock)
        if (rdata_valid)
            rv_count <= rv_count + 1;
    debug_wire_ack_handshake DUT (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .host_abort(host_abort),
        .cpu_wait_stop(cpu_wait_stop), .bus(bus), .bus_grant(bus_grant),
        .bus_rdata(bus_rdata), .rdata_word(rdata_word), .rdata_valid(rdata_valid),
        .ack_busy(ack_busy), .debug_wire_pin_in(pin), .debug_wire_pin_out(pin_out),
        .debug_wire_pin_oe(pin_oe));
    debug_host_model host (.clock(clock), .pin_oe(pin_oe), .pin_out(pin_out), .pin(pin),
        .ack_len(ack_len), .ack_count(ack_count));
    task automatic close_out();
        if (fails == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic wait_ack(int n);
        for (int i = 0; i < 100 && ack_count == n; i++)
            tick(1);
        chk("ack_seen", 16'(ack_count - n), 16'h0001);
        if (ack_count == n)
            close_out();
    endtask
    // ------------------------------
    // Command with optional bus cycle
    // ------------------------------
    task automatic run_cmd(logic rd, logic wr, logic [15:0] a, int dly, logic [15:0] w,
        logic cpu);
        int n;
        int r;
        n = ack_count;
        r = rv_count;
        cmd = '{8'h01, a, w, rd, wr, cpu};
        cmd_valid = 1;
        tick(1);
        cmd_valid = 0;
        if (rd | wr)
        begin
            chk("req", 16'(bus.req), 16'h0001);
            chk("addr", bus.addr, {a[15:1], 1'b0});
            chk("we", 16'(bus.we), 16'(wr));
            if (wr)
                chk("wdata", bus.wdata, w);
            tick(dly);
            chk("steal", 16'(bus.steal),
                16'(dly >= int'(debug_wire_pkg::STEAL_AFTER_CYCLES)));
            chk("early", 16'(ack_count - n), 16'h0000);
            bus_rdata = w;
            bus_grant = 1;
            tick(1);
            bus_grant = 0;
        end
        wait_ack(n);
        chk("len", 16'(ack_len), 16'h0010);
        chk("ready", 16'({cmd_ready, pin_oe}), 16'h0002);
        chk("rdata_valid", 16'(rv_count - r), 16'(rd));
        if (rd)
            chk("word", rdata_word, w);
    endtask
    task automatic drop_cmd();
        int n;
        n = ack_count;
        cpu_wait_stop = 1;
        cmd = '{8'h02, 16'h0100, 16'h0055, 1'b0, 1'b1, 1'b1};
        cmd_valid = 1;
        tick(1);
        cpu_wait_stop = 0;
        tick(60);
        cmd_valid = 0;
        chk("dropped", 16'(ack_count - n), 16'h0000);
        chk("no_bus", 16'(bus.req), 16'h0000);
        chk("pending", 16'({ack_busy, cmd_ready}), 16'h0002);
        host_abort = 1;
        tick(1);
        host_abort = 0;
        chk("aborted", 16'({cmd_ready, pin_oe}), 16'h0002);
    endtask
    initial
    begin
        tick(3);
        chk("rst_oe", 16'(pin_oe), 16'h0000);
        rst_n = 1;
        tick(4);
        run_cmd(1, 0, 16'h1235, 2, 16'hbeef, 0);
        run_cmd(0, 1, 16'h2000, 8, 16'h0f0f, 1);
        run_cmd(0, 0, 16'h0000, 0, 16'h0000, 0);
        drop_cmd();
        cpu_wait_stop = 1;
        run_cmd(1, 0, 16'h2001, 12, 16'ha5c3, 0);
        cpu_wait_stop = 0;
        close_out();
    end
endmodule
